/* shared/svoc_pkg.sv */
package svoc_pkg;
    // register bus shape
    localparam int NREG = 39;
    localparam int AW = 17;
    localparam int DW = 32;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // register identities, same order as the table below
    typedef enum int {
        RG_TSEL, RG_HPREP_NS, RG_HEXIT_H, RG_HEXIT_L, RG_HZERO_UI, RG_HTRAIL_UI,
        RG_CZERO_UI, RG_CPREP_UI, RG_CPOST_UI, RG_CTRAIL_UI, RG_LPX_UI, RG_HPREP_UI,
        RG_HEXIT_UI, RG_PERIOD, RG_LN01, RG_LN45, RG_LN67, RG_CPRE, RG_CKLN, RG_LN23,
        RG_SLEEP, RG_TEST, RG_DPAT, RG_FEND_WAIT, RG_CPAT, RG_SYNC, RG_FILL0H,
        RG_FILL0L, RG_FILL1H, RG_FILL1L, RG_FS, RG_FEND, RG_LS, RG_LEND, RG_MISC,
        RG_BLKH, RG_BLKL, RG_LLEN_H, RG_LLEN_L
    } svoc_reg_t;
    // index (byte address is four times it), reset value, implemented bits
    typedef struct packed {
        logic [15:0] ofs;
        logic [7:0] rst;
        logic [7:0] msk;
    } svoc_rdef_t;
    localparam svoc_rdef_t RDEF [NREG] = '{
        '{16'h4802, 8'h00, 8'hff}, '{16'h4827, 8'h55, 8'hff}, '{16'h4828, 8'h00, 8'h03},
        '{16'h4829, 8'h64, 8'hff}, '{16'h482a, 8'h06, 8'h3f}, '{16'h482b, 8'h04, 8'h3f},
        '{16'h482c, 8'h00, 8'h3f}, '{16'h482d, 8'h00, 8'hff}, '{16'h482e, 8'h34, 8'h3f},
        '{16'h482f, 8'h00, 8'h3f}, '{16'h4830, 8'h00, 8'h3f}, '{16'h4831, 8'h64, 8'hff},
        '{16'h4832, 8'h00, 8'h3f}, '{16'h4837, 8'h10, 8'hff}, '{16'h4838, 8'h00, 8'hff},
        '{16'h483a, 8'h00, 8'hff}, '{16'h483b, 8'h00, 8'hff}, '{16'h483c, 8'h02, 8'h0f},
        '{16'h483d, 8'h00, 8'hff}, '{16'h4848, 8'h00, 8'hff}, '{16'h484a, 8'h27, 8'h3f},
        '{16'h484c, 8'h03, 8'h37}, '{16'h484d, 8'hb6, 8'hff}, '{16'h484e, 8'h10, 8'hff},
        '{16'h484f, 8'h55, 8'hff}, '{16'h4a00, 8'h2a, 8'hff}, '{16'h4a02, 8'h00, 8'h0f},
        '{16'h4a03, 8'h80, 8'hff}, '{16'h4a04, 8'h00, 8'h0f}, '{16'h4a05, 8'h10, 8'hff},
        '{16'h4a06, 8'haa, 8'hff}, '{16'h4a07, 8'h55, 8'hff}, '{16'h4a08, 8'h99, 8'hff},
        '{16'h4a09, 8'h66, 8'hff}, '{16'h4a0a, 8'h00, 8'h07}, '{16'h4a0c, 8'h00, 8'h0f},
        '{16'h4a0d, 8'h05, 8'hff}, '{16'h4a0e, 8'h00, 8'hff}, '{16'h4a0f, 8'h00, 8'hff}
    };
    // field positions
    localparam int B_SEL_HI = 7, B_DIR_HI = 6, B_P_HI = 5, B_N_HI = 4;
    localparam int B_SEL_LO = 3, B_DIR_LO = 2, B_P_LO = 1, B_N_LO = 0;
    localparam int B_SLP_MAN = 2, B_SLP_CK = 1, B_SLP_DA = 0;
    localparam int B_PRBS = 5, B_HS_ONLY = 4;
    localparam int B_TWO8 = 7, B_SMAN = 6, B_ONE = 5, B_PINV = 4;
    localparam int B_CHID = 3, B_CCIRF = 2, B_SAV = 1, B_PERLANE = 0;
    localparam int B_LLEN_EN = 2, B_LN2 = 1, B_CHK = 0;
    localparam int S_HPREP = 7, S_CPREP = 6, S_CPOST = 5, S_CTRAIL = 4;
    localparam int S_HEXIT = 3, S_HZERO = 2, S_HTRAIL = 1, S_CZERO = 0;
    // timing limits in double-rate pixel clock cycles
    typedef struct packed {
        logic [9:0] hs_prep, hs_prep_max, hs_exit, hs_zero, hs_trail;
        logic [9:0] clk_zero, clk_prep, clk_post, clk_trail, lpx;
        logic [3:0] clk_pre;
    } svoc_tcyc_t;
    // nanosecond floors held by the earlier transmitter controls
    typedef struct packed {
        logic [9:0] hs_prep, hs_zero, hs_trail, clk_zero;
        logic [9:0] clk_prep, clk_post, clk_trail, lpx;
    } svoc_tns_t;
    typedef enum logic [1:0] {SK_FSTART, SK_FEND, SK_LSTART, SK_LEND} svoc_sync_t;
    // differential framer settings
    typedef struct packed {
        logic per_lane, chan_id, one_lane, two_sync8, sav_first, ccir_f, pclk_inv;
        logic line2_sel, chk_pcnt;
        logic [11:0] blank_count, filler_word_zero, filler_word_one;
        logic [15:0] line_length;
    } svoc_lvds_t;
endpackage : svoc_pkg

/* hw/svoc_top.sv */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Operation
// R1: hs prepare upper limit is ns register plus unit interval times ui upper count
// R2: hs exit floor is 10 bits, two high bits first, low byte default 0x64
// R3: six-bit ui adders for zero, trail, clock zero, post, trail and exit
// R4: clock prepare ui register splits into upper and lower nibble counts
// R5: hs prepare ui register splits into upper and lower nibbles, default 0x64
// R6: low-power interval ui adder is six bits in double-rate clock units; the code counts it in unit intervals
// R7: double-rate clock period register, one fraction bit, is conversion reference
// R8: data lanes use auto direction unless selected, then manual direction and levels
// R9: clock lanes follow the same automatic or manual direction scheme
// R10: in sleep, manual enable drives lane states from clock and data bits
// R11: prbs enable and high-speed-only test mode keep lanes in high speed
// R12: test mode sends data pattern on data lanes and clock pattern on clock
// R13: frame end packet waits twice the delay register after the last packet
// R14: sync codes split or per lane, channel id only in per-lane mode
// R15: manual sync mode uses programmable frame start and frame end codes
// R16: manual sync mode uses programmable line start and line end codes
// R17: framer honours one-lane, two-sync, sav-first and ccir f enables
// R18: blanking repeat count is 12 bits, high nibble and low byte
// R19: manual 16-bit line length is used when its enable bit is set
// R20: each timing is automatic when its select bit is clear, programmed when set; the code always programs hs_prep_max and clk_pre
// R21: byte registers, most significant byte at lower address, defaults after reset
module svoc_top
    import svoc_pkg::*;
#(
    parameter int LANES = 8,
    parameter int CKLANES = 2,
    parameter logic [7:0] FS_BUILTIN = 8'h01,
    parameter logic [7:0] FE_BUILTIN = 8'h02,
    parameter logic [7:0] LS_BUILTIN = 8'h03,
    parameter logic [7:0] LE_BUILTIN = 8'h04
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DW-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [DW-1:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] ui_period_half_ns,
    input wire svoc_tns_t floor_ns,
    input wire svoc_tcyc_t auto_timing,
    input wire logic lpx_select,
    output svoc_tcyc_t timing,
    output logic [3:0] clock_prep_ui_upper,
    output logic [3:0] clock_prep_ui_lower,
    output logic [3:0] hs_prep_ui_upper,
    output logic [3:0] hs_prep_ui_lower,
    input wire logic [LANES-1:0] lane_auto_dir,
    input wire logic [LANES-1:0] lane_auto_pos,
    input wire logic [LANES-1:0] lane_auto_neg,
    input wire logic [LANES-1:0] lane_lp_pos_in,
    input wire logic [LANES-1:0] lane_lp_neg_in,
    output logic [LANES-1:0] lane_lp_pos_out,
    output logic [LANES-1:0] lane_lp_neg_out,
    output logic [LANES-1:0] lane_pad_direction,
    input wire logic [CKLANES-1:0] clock_auto_dir,
    input wire logic [CKLANES-1:0] clock_auto_pos,
    input wire logic [CKLANES-1:0] clock_auto_neg,
    input wire logic [CKLANES-1:0] clock_lp_pos_in,
    input wire logic [CKLANES-1:0] clock_lp_neg_in,
    output logic [CKLANES-1:0] clock_lp_pos_out,
    output logic [CKLANES-1:0] clock_lp_neg_out,
    output logic [CKLANES-1:0] clock_pad_direction,
    output logic [LANES-1:0] lane_lp_seen,
    input wire logic sleep_active,
    input wire logic auto_clock_state,
    input wire logic auto_data_state,
    output logic sleep_clock_state,
    output logic sleep_data_state,
    output logic prbs_enable,
    output logic fast_signalling_test_enable,
    input wire logic [7:0] data_word_in,
    input wire logic [7:0] clock_word_in,
    output logic [7:0] data_word_out,
    output logic [7:0] clock_test_word,
    input wire logic double_rate_tick,
    input wire logic last_packet_done,
    output logic frame_end_go,
    input wire svoc_sync_t sync_kind,
    output logic [7:0] sync_word,
    input wire logic [15:0] auto_line_length,
    output svoc_lvds_t lvds_cfg
);
    // register storage and bus decode
    logic [7:0] regs_r [NREG];
    logic done_r;
    logic [DW-1:0] readdata_r;
    logic [NREG-1:0] hit;
    logic bus_req;
    logic bus_take;
    logic [7:0] rd_byte;
    logic wr_ok;

    assign bus_req = read | write;
    // every access answers one cycle after it is raised
    assign waitrequest = bus_req & ~done_r;
    assign bus_take = bus_req & done_r;
    assign wr_ok = write & byteenable[0] & bus_take;
    assign readdata = readdata_r;

    // one comparator per register; address must be word aligned
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_dec
            assign hit[gi] = (address[AW-1:2] == RDEF[gi].ofs[AW-3:0])
                && (address[1:0] == 2'b00);
        end
    endgenerate

    // read mux; unmapped locations read as zero
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_byte = regs_r[i] & RDEF[i].msk;
            end
        end
    end

    // handshake phase bit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= bus_req & ~done_r;
        end
    end

    // read data captured in the waiting cycle, stands at the answer edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            readdata_r <= UNMAPPED_READ;
        end else if (read & ~done_r) begin
            readdata_r <= {24'h000000, rd_byte};
        end
    end

    // R21 byte registers
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    regs_r[gi] <= RDEF[gi].rst;
                end else if (wr_ok && hit[gi]) begin
                    regs_r[gi] <= writedata[7:0] & RDEF[gi].msk;
                end
            end
        end
    endgenerate

    // conversion to double-rate cycles, all in half-ns: the period register
    // already carries one fraction bit, so doubling ns avoids a fraction
    function automatic logic [9:0] to_cyc(
        input logic [9:0] ns,
        input logic [5:0] ui,
        input logic [7:0] tui,
        input logic [7:0] per
    );
        logic [15:0] h;
        logic [15:0] p;
        // operands widened first so the product keeps all fourteen bits
        h = {5'h00, ns, 1'b0} + ({8'h00, tui} * {10'h000, ui});
        // a zero period would divide by zero, so it is taken as one
        p = (per == 8'h00) ? 16'h0001 : {8'h00, per};
        to_cyc = 10'((h + p - 16'h0001) / p);
    endfunction : to_cyc

    // named fields
    logic [7:0] tsel;
    logic [7:0] per;
    logic [7:0] tui;
    logic [9:0] hs_prep_upper_limit;
    logic [9:0] hs_leave_lower_limit;
    logic [5:0] hs_zero_ui_adder;
    logic [5:0] hs_trail_ui_adder;
    logic [5:0] clock_zero_ui_adder;
    logic [5:0] clock_post_ui_adder;
    logic [5:0] clock_trail_ui_adder;
    logic [5:0] lowpower_interval_ui_adder;
    logic [5:0] hs_leave_ui_adder;
    svoc_tcyc_t manual_cyc;
    svoc_tcyc_t timing_nxt;

    assign tsel = regs_r[RG_TSEL];
    // R7 period reference
    assign per = regs_r[RG_PERIOD];
    assign tui = ui_period_half_ns;
    assign hs_prep_upper_limit = {2'b00, regs_r[RG_HPREP_NS]};
    // R2 high bits at the lower address
    assign hs_leave_lower_limit = {regs_r[RG_HEXIT_H][1:0], regs_r[RG_HEXIT_L]};
    // R3 six-bit adders
    assign hs_zero_ui_adder = regs_r[RG_HZERO_UI][5:0];
    assign hs_trail_ui_adder = regs_r[RG_HTRAIL_UI][5:0];
    assign clock_zero_ui_adder = regs_r[RG_CZERO_UI][5:0];
    assign clock_post_ui_adder = regs_r[RG_CPOST_UI][5:0];
    assign clock_trail_ui_adder = regs_r[RG_CTRAIL_UI][5:0];
    assign hs_leave_ui_adder = regs_r[RG_HEXIT_UI][5:0];
    // R6 interval adder
    assign lowpower_interval_ui_adder = regs_r[RG_LPX_UI][5:0];
    // R4 clock prepare nibbles
    assign clock_prep_ui_upper = regs_r[RG_CPREP_UI][7:4];
    assign clock_prep_ui_lower = regs_r[RG_CPREP_UI][3:0];
    // R5 hs prepare nibbles
    assign hs_prep_ui_upper = regs_r[RG_HPREP_UI][7:4];
    assign hs_prep_ui_lower = regs_r[RG_HPREP_UI][3:0];

    // programmed limits; R1 upper limit adds ui times upper count
    assign manual_cyc.hs_prep_max = to_cyc(hs_prep_upper_limit,
        {2'b00, hs_prep_ui_upper}, tui, per);
    assign manual_cyc.hs_prep = to_cyc(floor_ns.hs_prep,
        {2'b00, hs_prep_ui_lower}, tui, per);
    assign manual_cyc.hs_exit = to_cyc(hs_leave_lower_limit, hs_leave_ui_adder, tui, per);
    assign manual_cyc.hs_zero = to_cyc(floor_ns.hs_zero, hs_zero_ui_adder, tui, per);
    assign manual_cyc.hs_trail = to_cyc(floor_ns.hs_trail, hs_trail_ui_adder, tui, per);
    assign manual_cyc.clk_zero = to_cyc(floor_ns.clk_zero, clock_zero_ui_adder, tui, per);
    assign manual_cyc.clk_prep = to_cyc(floor_ns.clk_prep,
        {2'b00, clock_prep_ui_lower}, tui, per);
    assign manual_cyc.clk_post = to_cyc(floor_ns.clk_post, clock_post_ui_adder, tui, per);
    assign manual_cyc.clk_trail = to_cyc(floor_ns.clk_trail, clock_trail_ui_adder, tui, per);
    assign manual_cyc.lpx = to_cyc(floor_ns.lpx, lowpower_interval_ui_adder, tui, per);
    assign manual_cyc.clk_pre = regs_r[RG_CPRE][3:0];

    // R20 per-parameter automatic or programmed choice; hs_prep_max and clk_pre are always programmed
    always_comb begin
        timing_nxt = auto_timing;
        timing_nxt.hs_prep_max = manual_cyc.hs_prep_max;
        timing_nxt.clk_pre = manual_cyc.clk_pre;
        if (tsel[S_HPREP]) timing_nxt.hs_prep = manual_cyc.hs_prep;
        if (tsel[S_CPREP]) timing_nxt.clk_prep = manual_cyc.clk_prep;
        if (tsel[S_CPOST]) timing_nxt.clk_post = manual_cyc.clk_post;
        if (tsel[S_CTRAIL]) timing_nxt.clk_trail = manual_cyc.clk_trail;
        if (tsel[S_HEXIT]) timing_nxt.hs_exit = manual_cyc.hs_exit;
        if (tsel[S_HZERO]) timing_nxt.hs_zero = manual_cyc.hs_zero;
        if (tsel[S_HTRAIL]) timing_nxt.hs_trail = manual_cyc.hs_trail;
        if (tsel[S_CZERO]) timing_nxt.clk_zero = manual_cyc.clk_zero;
        if (lpx_select) timing_nxt.lpx = manual_cyc.lpx;
    end

    // divider sits in front of this flop, so timing lags a write by a cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timing <= '0;
        end else begin
            timing <= timing_nxt;
        end
    end

    // lane override fields; two lanes share one register
    logic [7:0] lane_ovr [4];
    assign lane_ovr[0] = regs_r[RG_LN01];
    assign lane_ovr[1] = regs_r[RG_LN23];
    assign lane_ovr[2] = regs_r[RG_LN45];
    assign lane_ovr[3] = regs_r[RG_LN67];

    // R8 data lane pads, odd lanes in the low nibble
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            logic [3:0] f;
            assign f = (gi % 2 == 1) ? lane_ovr[gi/2][B_N_LO+3:B_N_LO]
                : lane_ovr[gi/2][B_N_HI+3:B_N_HI];
            assign lane_pad_direction[gi] = f[3] ? f[2] : lane_auto_dir[gi];
            assign lane_lp_pos_out[gi] = f[3] ? f[1] : lane_auto_pos[gi];
            assign lane_lp_neg_out[gi] = f[3] ? f[0] : lane_auto_neg[gi];
            // readback flags a lane whose positive and negative input levels differ
            assign lane_lp_seen[gi] = lane_lp_pos_in[gi] ^ lane_lp_neg_in[gi];
        end
    endgenerate

    // R9 clock lane pads
    generate
        for (gi = 0; gi < CKLANES; gi++) begin : g_ck
            logic [3:0] f;
            assign f = (gi % 2 == 1) ? regs_r[RG_CKLN][B_N_LO+3:B_N_LO]
                : regs_r[RG_CKLN][B_N_HI+3:B_N_HI];
            assign clock_pad_direction[gi] = f[3] ? f[2] : clock_auto_dir[gi];
            assign clock_lp_pos_out[gi] = f[3] ? f[1] : clock_auto_pos[gi];
            assign clock_lp_neg_out[gi] = f[3] ? f[0] : clock_auto_neg[gi];
        end
    endgenerate

    // R10 sleep-time bus state
    logic slp_man;
    assign slp_man = sleep_active & regs_r[RG_SLEEP][B_SLP_MAN];
    assign sleep_clock_state = slp_man ? regs_r[RG_SLEEP][B_SLP_CK] : auto_clock_state;
    assign sleep_data_state = slp_man ? regs_r[RG_SLEEP][B_SLP_DA] : auto_data_state;

    // R11 test enables
    assign prbs_enable = regs_r[RG_TEST][B_PRBS];
    assign fast_signalling_test_enable = regs_r[RG_TEST][B_HS_ONLY];

    // R12 test words replace the payload while test mode is on
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_word_out <= 8'h00;
            clock_test_word <= 8'h00;
        end else if (fast_signalling_test_enable) begin
            data_word_out <= regs_r[RG_DPAT];
            clock_test_word <= regs_r[RG_CPAT];
        end else begin
            data_word_out <= data_word_in;
            clock_test_word <= clock_word_in;
        end
    end

    // R13 frame end wait, counted in double-rate ticks
    typedef enum logic {FW_IDLE, FW_WAIT} svoc_fw_t;
    svoc_fw_t fw_r;
    svoc_fw_t fw_nxt;
    logic [8:0] fw_cnt_r;
    logic [8:0] fw_cnt_nxt;
    logic frame_end_go_nxt;
    logic [7:0] frame_end_wait_half;
    assign frame_end_wait_half = regs_r[RG_FEND_WAIT];

    always_comb begin
        fw_nxt = fw_r;
        fw_cnt_nxt = fw_cnt_r;
        frame_end_go_nxt = 1'b0;
        unique case (fw_r)
            FW_IDLE: begin
                if (last_packet_done) begin
                    fw_nxt = FW_WAIT;
                    fw_cnt_nxt = {frame_end_wait_half, 1'b0};
                end
            end
            FW_WAIT: begin
                if (fw_cnt_r == 9'h000) begin
                    fw_nxt = FW_IDLE;
                    frame_end_go_nxt = 1'b1;
                end else if (double_rate_tick) begin
                    fw_cnt_nxt = fw_cnt_r - 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fw_r <= FW_IDLE;
            fw_cnt_r <= 9'h000;
            frame_end_go <= 1'b0;
        end else begin
            fw_r <= fw_nxt;
            fw_cnt_r <= fw_cnt_nxt;
            frame_end_go <= frame_end_go_nxt;
        end
    end

    // R15 R16 sync word, programmable only in manual mode
    logic sync_man;
    logic [7:0] sync_nxt;
    assign sync_man = regs_r[RG_SYNC][B_SMAN];
    always_comb begin
        unique case (sync_kind)
            SK_FSTART: sync_nxt = sync_man ? regs_r[RG_FS] : FS_BUILTIN;
            SK_FEND: sync_nxt = sync_man ? regs_r[RG_FEND] : FE_BUILTIN;
            SK_LSTART: sync_nxt = sync_man ? regs_r[RG_LS] : LS_BUILTIN;
            SK_LEND: sync_nxt = sync_man ? regs_r[RG_LEND] : LE_BUILTIN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_word <= 8'h00;
        end else begin
            sync_word <= sync_nxt;
        end
    end

    // framer settings
    svoc_lvds_t lvds_nxt;
    always_comb begin
        lvds_nxt = '0;
        // R14 placement and channel id
        lvds_nxt.per_lane = regs_r[RG_SYNC][B_PERLANE];
        lvds_nxt.chan_id = regs_r[RG_SYNC][B_PERLANE] & regs_r[RG_SYNC][B_CHID];
        // R17 framer enables
        lvds_nxt.one_lane = regs_r[RG_SYNC][B_ONE];
        lvds_nxt.two_sync8 = regs_r[RG_SYNC][B_TWO8];
        lvds_nxt.sav_first = regs_r[RG_SYNC][B_SAV];
        lvds_nxt.ccir_f = regs_r[RG_SYNC][B_CCIRF];
        lvds_nxt.pclk_inv = regs_r[RG_SYNC][B_PINV];
        lvds_nxt.line2_sel = regs_r[RG_MISC][B_LN2];
        lvds_nxt.chk_pcnt = regs_r[RG_MISC][B_CHK];
        // R18 blanking count
        lvds_nxt.blank_count = {regs_r[RG_BLKH][3:0], regs_r[RG_BLKL]};
        lvds_nxt.filler_word_zero = {regs_r[RG_FILL0H][3:0], regs_r[RG_FILL0L]};
        lvds_nxt.filler_word_one = {regs_r[RG_FILL1H][3:0], regs_r[RG_FILL1L]};
        // R19 manual line length
        lvds_nxt.line_length = regs_r[RG_MISC][B_LLEN_EN]
            ? {regs_r[RG_LLEN_H], regs_r[RG_LLEN_L]} : auto_line_length;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lvds_cfg <= '0;
        end else begin
            lvds_cfg <= lvds_nxt;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    bus_one_wait_a: assert property ( // R21
        bus_req && !done_r |=> !waitrequest) else $error("bus answer late");
    hold_write_a: assert property ( // R21
        write && byteenable[0] && !waitrequest && hit[RG_FEND_WAIT]
        |=> regs_r[RG_FEND_WAIT] == $past(writedata[7:0]))
        else $error("write lost");
    lane_manual_a: assert property ( // R8
        lane_ovr[0][B_SEL_HI] |-> lane_pad_direction[0] == lane_ovr[0][B_DIR_HI])
        else $error("lane direction not manual");
    clock_auto_a: assert property ( // R9
        !regs_r[RG_CKLN][B_SEL_HI] |-> clock_pad_direction[0] == clock_auto_dir[0])
        else $error("clock direction not auto");
    sleep_state_a: assert property ( // R10
        slp_man |-> sleep_data_state == regs_r[RG_SLEEP][B_SLP_DA])
        else $error("sleep state wrong");
    test_word_a: assert property ( // R12
        fast_signalling_test_enable |=> data_word_out == $past(regs_r[RG_DPAT]))
        else $error("test pattern missing");
    fend_wait_a: assert property ( // R13
        fw_r == FW_IDLE && last_packet_done && regs_r[RG_FEND_WAIT] == 8'h00
        |=> ##1 frame_end_go) else $error("frame end not sent");
    fend_early_a: assert property ( // R13
        frame_end_go |-> $past(fw_cnt_r) == 9'h000) else $error("frame end early");
    sync_code_a: assert property ( // R15
        sync_man && sync_kind == SK_FSTART |=> sync_word == $past(regs_r[RG_FS]))
        else $error("manual sync code");
    line_len_a: assert property ( // R19
        regs_r[RG_MISC][B_LLEN_EN]
        |=> lvds_cfg.line_length == {$past(regs_r[RG_LLEN_H]), $past(regs_r[RG_LLEN_L])})
        else $error("manual line length");
endmodule : svoc_top

/* verification/svoc_host_model.sv */
`timescale 1ns/1ps
// far-side receiver on the low-power lines; a released line shows the
// inverse of its last level, so a stale value can never pass for a drive
module svoc_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] pad_dir,
    input wire logic [7:0] pos_out,
    output logic [7:0] pos_in
);
    initial pos_in = 8'h00;
    always @(posedge ref_clk) begin
        pos_in <= (pad_dir & pos_out) | (~pad_dir & ~pos_in);
    end
endmodule : svoc_host_model

/* verification/serial_video_output_config_tb.sv */
`timescale 1ns/1ps
module serial_video_output_config_tb import svoc_pkg::*; ;
    logic ref_clk = 0, nrst = 0, read = 0, write = 0, lpx_select = 0, sleep_active = 1;
    logic auto_clock_state = 0, auto_data_state = 0, double_rate_tick = 1;
    logic last_packet_done = 0, waitrequest, sleep_clock_state, sleep_data_state;
    logic prbs_enable, fast_signalling_test_enable, frame_end_go;
    logic [16:0] address = '0;
    logic [31:0] writedata = '0, readdata;
    logic [3:0] byteenable = 4'hf, clock_prep_ui_upper, clock_prep_ui_lower;
    logic [3:0] hs_prep_ui_upper, hs_prep_ui_lower;
    logic [7:0] ui_period_half_ns = 8'h04, data_word_in = 8'h11, clock_word_in = 8'h22;
    logic [7:0] lane_auto_dir = 8'h02, lane_auto_pos = '0, lane_auto_neg = '0;
    logic [7:0] lane_lp_pos_in, lane_lp_neg_in = '0, lane_lp_pos_out, lane_lp_neg_out;
    logic [7:0] lane_pad_direction, lane_lp_seen, data_word_out, clock_test_word, sync_word, q;
    logic [1:0] clock_auto_dir = '0, clock_auto_pos = '0, clock_auto_neg = '0;
    logic [1:0] clock_lp_pos_in = '0, clock_lp_neg_in = '0, clock_lp_pos_out;
    logic [1:0] clock_lp_neg_out, clock_pad_direction;
    logic [15:0] auto_line_length = 16'h0123;
    svoc_tns_t floor_ns = '0;
    svoc_tcyc_t auto_timing = '0, timing;
    svoc_sync_t sync_kind = SK_FSTART;
    svoc_lvds_t lvds_cfg;
    int num_errors = 0, samples_checked = 0, cyc = 0, n0, n2;
    // offset, reset value, value written, value read back
    logic [39:0] rows [17] = '{40'h4827_55_a5_a5, 40'h4828_00_ff_03, 40'h482a_06_ff_3f,
        40'h4831_64_9c_9c, 40'h4838_00_e0_e0, 40'h483d_00_0c_0c, 40'h484a_27_07_07,
        40'h484c_03_10_10, 40'h484d_b6_3c_3c, 40'h484f_55_c3_c3, 40'h4a00_2a_6a_6a,
        40'h4a0a_00_04_04, 40'h4a0c_00_ff_0f, 40'h4a0d_05_ff_ff, 40'h4a0e_00_12_12,
        40'h4a0f_00_34_34, 40'h4802_00_08_08};
    logic [7:0] codes [4] = '{8'haa, 8'h55, 8'h99, 8'h66};
    svoc_top svoc_top_i (.*);
    svoc_host_model svoc_host_model_i (.ref_clk(ref_clk), .pad_dir(lane_pad_direction),
        .pos_out(lane_lp_pos_out), .pos_in(lane_lp_pos_in));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    // one bus cycle; held until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [15:0] o, input logic [7:0] d);
        address <= {o[14:0], 2'b00};
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask : acc
    // edges from the last-packet pulse to the frame-end pulse
    task automatic fe(input logic [7:0] d, output int n);
        acc(1, 16'h484e, d);
        last_packet_done <= 1'b1;
        @(posedge ref_clk);
        last_packet_done <= 1'b0;
        n = 0;
        // a pulse that never comes is caught by the hang guard
        while (frame_end_go !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : fe
    task results;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            acc(0, rows[i][39:24], 8'h00);
            chk(q, rows[i][23:16]);
            acc(1, rows[i][39:24], rows[i][15:8]);
            acc(0, rows[i][39:24], 8'h00);
            chk(q, rows[i][7:0]);
        end
        chk({hs_prep_ui_upper, hs_prep_ui_lower}, 16'h9c);
        chk({clock_prep_ui_upper, clock_prep_ui_lower}, 16'h00);
        // 165 ns + 9 ui of 2 ns over an 8 ns period, rounded up
        chk(timing.hs_prep_max, 16'h17);
        // exit floor 0x364 ns over 8 ns, rounded up, once its select is set
        chk(timing.hs_exit, 16'h6d);
        chk(lane_lp_seen[1:0], 16'h1);
        chk({lvds_cfg.per_lane, lvds_cfg.chan_id, lvds_cfg.one_lane}, 16'h1);
        chk({sleep_clock_state, sleep_data_state}, 16'h3);
        chk({lane_pad_direction[1:0], lane_lp_pos_out[0], lane_lp_neg_out[0]}, 16'he);
        chk({clock_pad_direction, clock_lp_pos_out, clock_lp_neg_out}, 16'h20);
        chk({prbs_enable, fast_signalling_test_enable}, 16'h1);
        chk({data_word_out, clock_test_word}, 16'h3cc3);
        chk(lvds_cfg.line_length, 16'h1234);
        chk(lvds_cfg.blank_count, 16'hfff);
        // manual sync mode: every kind gives its programmed code
        foreach (codes[k]) begin
            sync_kind <= svoc_sync_t'(k);
            repeat (2) @(posedge ref_clk);
            chk(sync_word, codes[k]);
        end
        acc(0, 16'h4836, 8'h00);
        chk(q, 16'h0);
        // mid-run reset: outputs clear, registers return to defaults
        nrst <= 1'b0;
        @(posedge ref_clk);
        chk({sync_word, data_word_out}, 16'h0);
        nrst <= 1'b1;
        @(posedge ref_clk);
        acc(0, 16'h4a00, 8'h00);
        chk(q, 16'h2a);
        fe(8'h00, n0);
        fe(8'h02, n2);
        chk(16'(n2 - n0), 16'h4);
        results();
    end
endmodule : serial_video_output_config_tb
